//--- rtl/rpc_pkg.sv
// Package: register map, field layout and carriers of the region protection checker
package rpc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] RPC_ADDR_UNIT_INFO  = 32'hE000ED90;
    localparam logic [31:0] RPC_ADDR_CONTROL    = 32'hE000ED94;
    localparam logic [31:0] RPC_ADDR_SELECT     = 32'hE000ED98;
    localparam logic [31:0] RPC_ADDR_BASE       = 32'hE000ED9C;
    localparam logic [31:0] RPC_ADDR_LIMIT      = 32'hE000EDA0;
    localparam logic [31:0] RPC_ADDR_ATTR_LOW   = 32'hE000EDC0;
    localparam logic [31:0] RPC_ADDR_ATTR_HIGH  = 32'hE000EDC4;
    localparam logic [31:0] RPC_ADDR_IRQ_STATUS = 32'hE000EDD0;
    localparam logic [31:0] RPC_ADDR_IRQ_ENABLE = 32'hE000EDD4;
    localparam logic [31:0] RPC_ADDR_IRQ_CLEAR  = 32'hE000EDD8;
    localparam logic [31:0] RPC_ADDR_FAULT_ADDR = 32'hE000EDDC;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          RPC_COUNT_LSB      = 8;
    localparam int          RPC_COUNT_MSB      = 15;
    localparam int          RPC_SEPARATE_BIT   = 0;
    localparam int          RPC_CTRL_ENABLE    = 0;
    localparam int          RPC_CTRL_HFNMI     = 1;
    localparam int          RPC_CTRL_PRIVDEF   = 2;
    localparam logic [2:0]  RPC_CTRL_RESET     = 3'h0;
    localparam logic [7:0]  RPC_REGIONS_BUILT  = 8'h08;
    localparam logic [7:0]  RPC_REGIONS_NONE   = 8'h00;
    localparam int          RPC_ADDR_LSB       = 5;
    localparam int          RPC_RLAR_EN        = 0;
    localparam int          RPC_RBAR_XN        = 0;
    localparam int          RPC_RBAR_AP_LSB    = 1;
    localparam int          RPC_RBAR_SH_LSB    = 3;
    localparam int          RPC_RLAR_IDX_LSB   = 1;
    localparam logic [4:0]  RPC_LIMIT_FILL     = 5'h1F;
    localparam logic [31:0] RPC_SCS_BASE       = 32'hE000E000;
    localparam logic [31:0] RPC_SCS_TOP        = 32'hE000EFFF;
    localparam logic [31:0] RPC_VTAB_TOP       = 32'h000003FF;
    localparam int          RPC_EVT_PROHIBIT   = 0;
    localparam int          RPC_EVT_OVERLAP    = 1;
    localparam logic [1:0]  RPC_RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RPC_RESP_SLVERR    = 2'h2;

    // Attribute byte encodings: upper nibble zero means device memory
    localparam logic [7:0]  RPC_ATTR_DEV_ORDERED = 8'h04;
    localparam logic [7:0]  RPC_ATTR_DEV_STRICT  = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        write;
        logic        fetch;
        logic        priv;
        logic        handler_hf;
    } rpc_access_t;

    typedef struct packed {
        logic        valid;
        logic        fault;
        logic        overlap;
        logic [7:0]  attr;
        logic        shareable;
        logic        ordered;
        logic [3:0]  region;
        logic        hit;
    } rpc_result_t;

    typedef struct packed {
        logic [26:0] base;
        logic [1:0]  sh;
        logic [1:0]  ap;
        logic        xn;
        logic [26:0] limit;
        logic [2:0]  attr_idx;
        logic        en;
    } rpc_region_t;

endpackage

//--- rtl/rpc_region_match.sv
// One region comparator: hit and permission check for one region
`timescale 1ns/1ps
`default_nettype none
module rpc_region_match
    import rpc_pkg::*;
(
    input  wire rpc_region_t cfg_i,
    input  wire rpc_access_t acc_i,
    output logic             hit_o,
    output logic             deny_o
);
    // ------------------------------------------------------------
    // Address window and permission decode
    // ------------------------------------------------------------
    logic [26:0] page;
    assign page  = acc_i.addr[31:RPC_ADDR_LSB];
    assign hit_o = cfg_i.en && (page >= cfg_i.base) && (page <= cfg_i.limit);
    // AP[1] read-only, AP[0] unprivileged allowed, XN no fetch
    always_comb
    begin
        deny_o = 1'b0;
        if (!cfg_i.ap[0] && !acc_i.priv)
            deny_o = 1'b1;
        if (cfg_i.ap[1] && acc_i.write)
            deny_o = 1'b1;
        if (cfg_i.xn && acc_i.fetch)
            deny_o = 1'b1;
    end
endmodule
`default_nettype wire

//--- rtl/rpc_checker.sv
// Top: region protection checker with register file on AXI4-Lite
//
// Behaviour
// - Address inside two or more enabled regions raises a fault.
// - Fetches and data accesses use one shared region map.
// - Prohibited access signals a severe fault to the core.
// - Secure and non-secure units optional; this build holds one unit.
// - Each region holds its own base, limit, permissions, attributes.
// - Matched region attributes are exported with each access; this build exports them only while protection is active (en_eff), else 0x00.
// - Ordered device memory accesses are flagged for program order.
// - Strongly ordered regions always report shareable.
// - Info register bits [15:8] report number of regions.
// - Region count reads 0x00 without unit, 0x8 with it.
// - Info register bit 0 always reads zero: unified map.
// - Control register at 0xE000ED94 resets to zero.
// - Select, base and limit registers at ED98, ED9C, EDA0.
// - Attribute indirection registers at EDC0 and EDC4.
// - Normal memory supports shared or not with any cacheability.
// - With protection off the default map applies to everyone.
// - With protection on, control space and vector table always pass.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rpc_checker
    import rpc_pkg::*;
#(
    parameter int NUM_REGIONS = 8,
    parameter bit UNIT_BUILT  = 1'b1
)
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    // AXI4-Lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Core access path
    input  wire rpc_access_t acc_i,
    output rpc_result_t      res_o,
    output logic             irq_o
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_REGIONS < 1 || NUM_REGIONS > 16)
    begin : g_bad_regions
        $error("NUM_REGIONS must be 1 to 16");
    end

    localparam int RW = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [2:0]     ctrl;
    logic [7:0]     sel;
    rpc_region_t    regions [NUM_REGIONS];
    logic [31:0]    attr_lo;
    logic [31:0]    attr_hi;
    logic [1:0]     irq_status;
    logic [1:0]     irq_enable;
    logic [31:0]    fault_addr;

    // AXI write channel holding registers
    logic           aw_held;
    logic [31:0]    aw_addr;
    logic           w_held;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;

    // ------------------------------------------------------------
    // AXI write address and data capture, either order
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            aw_held <= 1'b0;
            aw_addr <= 32'h0;
            w_held  <= 1'b0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end
        else if (aw_held && w_held)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    logic        wr_fire;
    logic [31:0] wmask;
    assign wr_fire = aw_held && w_held;
    assign wmask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    // Write address decode, unmapped writes answer SLVERR
    logic wr_ok;
    always_comb
    begin
        unique case (aw_addr)
            RPC_ADDR_CONTROL, RPC_ADDR_SELECT, RPC_ADDR_BASE, RPC_ADDR_LIMIT,
            RPC_ADDR_ATTR_LOW, RPC_ADDR_ATTR_HIGH, RPC_ADDR_IRQ_ENABLE,
            RPC_ADDR_IRQ_CLEAR, RPC_ADDR_UNIT_INFO, RPC_ADDR_IRQ_STATUS,
            RPC_ADDR_FAULT_ADDR:
                wr_ok = 1'b1;
            default:
                wr_ok = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RPC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RPC_RESP_OKAY : RPC_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register writes; reserved bits dropped
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // Control register resets to zero
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ctrl <= RPC_CTRL_RESET;
        else if (wr_fire && aw_addr == RPC_ADDR_CONTROL && UNIT_BUILT)
            ctrl <= 3'(merge({29'h0, ctrl}, w_data, wmask));
    end

    // Select and attribute registers: contents undefined after reset, no reset
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_fire && aw_addr == RPC_ADDR_SELECT)
            sel <= 8'(merge({24'h0, sel}, w_data, wmask));
        if (wr_fire && aw_addr == RPC_ADDR_ATTR_LOW)
            attr_lo <= merge(attr_lo, w_data, wmask);
        if (wr_fire && aw_addr == RPC_ADDR_ATTR_HIGH)
            attr_hi <= merge(attr_hi, w_data, wmask);
    end

    // Region table: whole entries cleared at reset
    logic [31:0] cur_base;
    logic [31:0] cur_limit;
    logic        sel_ok;
    logic [RW-1:0] sel_idx;
    assign sel_idx = sel[RW-1:0];
    assign sel_ok  = (32'(sel) < 32'(NUM_REGIONS));
    always_comb
    begin
        cur_base  = 32'h0;
        cur_limit = 32'h0;
        if (sel_ok)
        begin
            cur_base  = {regions[sel_idx].base, regions[sel_idx].sh, regions[sel_idx].ap, regions[sel_idx].xn};
            cur_limit = {regions[sel_idx].limit, 1'b0, regions[sel_idx].attr_idx, regions[sel_idx].en};
        end
    end

    for (genvar g = 0; g < NUM_REGIONS; g++)
    begin : g_region_regs
        logic [31:0] nb;
        logic [31:0] nl;
        assign nb = merge(cur_base, w_data, wmask);
        assign nl = merge(cur_limit, w_data, wmask);
        // Per-region fields settable independently, one process per entry
        always_ff @(posedge clk_sys_i or negedge resetn_i)
        begin
            if (!resetn_i)
                regions[g] <= '0;
            else
            begin
                if (wr_fire && aw_addr == RPC_ADDR_BASE && sel_idx == RW'(g) && sel_ok)
                begin
                    regions[g].base <= nb[31:RPC_ADDR_LSB];
                    regions[g].sh   <= nb[RPC_RBAR_SH_LSB +: 2];
                    regions[g].ap   <= nb[RPC_RBAR_AP_LSB +: 2];
                    regions[g].xn   <= nb[RPC_RBAR_XN];
                end
                if (wr_fire && aw_addr == RPC_ADDR_LIMIT && sel_idx == RW'(g) && sel_ok)
                begin
                    regions[g].limit    <= nl[31:RPC_ADDR_LSB];
                    regions[g].attr_idx <= nl[RPC_RLAR_IDX_LSB +: 3];
                    regions[g].en       <= nl[RPC_RLAR_EN];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Access check against the one unified map
    // ------------------------------------------------------------
    logic [NUM_REGIONS-1:0] hits;
    logic [NUM_REGIONS-1:0] denies;
    for (genvar g = 0; g < NUM_REGIONS; g++)
    begin : g_match
        rpc_region_match u_match (
            .cfg_i  (regions[g]),
            .acc_i  (acc_i),
            .hit_o  (hits[g]),
            .deny_o (denies[g])
        );
    end

    logic        en_eff;
    logic        always_ok;
    logic        overlap;
    logic        any_hit;
    logic        deny;
    logic [3:0]  first;
    logic [7:0]  attr;
    logic [63:0] attr_all;
    assign attr_all = {attr_hi, attr_lo};
    // Protection active unless disabled or in severe handler without opt-in
    assign en_eff    = UNIT_BUILT && ctrl[RPC_CTRL_ENABLE] && !(acc_i.handler_hf && !ctrl[RPC_CTRL_HFNMI]);
    assign always_ok = (acc_i.addr >= RPC_SCS_BASE && acc_i.addr <= RPC_SCS_TOP)
                    || (acc_i.addr <= RPC_VTAB_TOP);
    assign overlap   = ($countones(hits) > 1);
    assign any_hit   = |hits;
    always_comb
    begin
        first = 4'h0;
        for (int i = NUM_REGIONS - 1; i >= 0; i--)
            if (hits[i])
                first = 4'(i);
    end
    assign attr = any_hit ? attr_all[8*regions[first[RW-1:0]].attr_idx +: 8] : 8'h00;

    // Fault decision: default map when off, background for privileged when enabled
    always_comb
    begin
        deny = 1'b0;
        if (en_eff && !always_ok)
        begin
            if (overlap)
                deny = 1'b1;
            else if (any_hit)
                deny = |(hits & denies);
            else
                deny = !(acc_i.priv && ctrl[RPC_CTRL_PRIVDEF]);
        end
    end

    // Registered result with exported attributes
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            res_o <= '0;
        else
        begin
            res_o.valid     <= acc_i.valid;
            res_o.fault     <= acc_i.valid && deny;
            res_o.overlap   <= acc_i.valid && en_eff && !always_ok && overlap;
            res_o.hit       <= en_eff && any_hit;
            res_o.region    <= first;
            res_o.attr      <= (en_eff && any_hit) ? attr : 8'h00;
            res_o.ordered   <= (en_eff && any_hit) && attr[7:4] == 4'h0
                                && (attr == RPC_ATTR_DEV_ORDERED || attr == RPC_ATTR_DEV_STRICT);
            res_o.shareable <= (en_eff && any_hit) && (attr[7:4] == 4'h0
                                || regions[first[RW-1:0]].sh[1]);
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, enable and clear
    // ------------------------------------------------------------
    logic [1:0] evt;
    assign evt = {res_o.overlap, res_o.fault && !res_o.overlap};
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_status <= 2'h0;
            irq_enable <= 2'h0;
            fault_addr <= 32'h0;
        end
        else
        begin
            // Set wins over a clear in the same cycle
            if (wr_fire && aw_addr == RPC_ADDR_IRQ_CLEAR)
                irq_status <= (irq_status & ~(w_data[1:0] & wmask[1:0])) | evt;
            else
                irq_status <= irq_status | evt;
            if (wr_fire && aw_addr == RPC_ADDR_IRQ_ENABLE)
                irq_enable <= 2'(merge({30'h0, irq_enable}, w_data, wmask));
            if (acc_i.valid && deny)
                fault_addr <= acc_i.addr;
        end
    end
    assign irq_o = |(irq_status & irq_enable);

    // ------------------------------------------------------------
    // AXI read channel, one cycle after address
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb
    begin
        rd_ok  = 1'b1;
        rd_val = 32'h0;
        unique case (s_axi_araddr)
            RPC_ADDR_UNIT_INFO:
                rd_val[RPC_COUNT_MSB:RPC_COUNT_LSB] = UNIT_BUILT ? RPC_REGIONS_BUILT
                                                                : RPC_REGIONS_NONE;
            RPC_ADDR_CONTROL:    rd_val[2:0] = ctrl;
            RPC_ADDR_SELECT:     rd_val[7:0] = sel;
            RPC_ADDR_BASE:       rd_val = cur_base;
            RPC_ADDR_LIMIT:      rd_val = cur_limit;
            RPC_ADDR_ATTR_LOW:   rd_val = attr_lo;
            RPC_ADDR_ATTR_HIGH:  rd_val = attr_hi;
            RPC_ADDR_IRQ_STATUS: rd_val[1:0] = irq_status;
            RPC_ADDR_IRQ_ENABLE: rd_val[1:0] = irq_enable;
            RPC_ADDR_IRQ_CLEAR:  rd_val = 32'h0;
            RPC_ADDR_FAULT_ADDR: rd_val = fault_addr;
            default:             rd_ok = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RPC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? RPC_RESP_OKAY : RPC_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_bad_access;
        acc_i.valid && deny;
    endsequence
    sequence s_fault_seen;
        res_o.fault;
    endsequence

    a_overlap_fault: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        acc_i.valid && en_eff && !always_ok && overlap |=> res_o.fault && res_o.overlap)
        else $error("overlap did not fault");
    a_prohibit_fault: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_bad_access |=> s_fault_seen)
        else $error("prohibited access not faulted");
    a_disabled_pass: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !ctrl[RPC_CTRL_ENABLE] |=> !res_o.fault)
        else $error("fault while protection off");
    a_scs_pass: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        acc_i.valid && always_ok |=> !res_o.fault)
        else $error("control space access faulted");
    a_so_shared: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        res_o.ordered |-> res_o.shareable)
        else $error("ordered region not shareable");
    a_attr_export: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        en_eff && any_hit |=> res_o.hit && res_o.attr == $past(attr))
        else $error("attributes not exported");
    a_ctrl_reset: assert property (@(posedge clk_sys_i)
        $rose(resetn_i) |-> ctrl == 3'h0)
        else $error("control not zero after reset");
    a_info_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == RPC_ADDR_UNIT_INFO
        |=> s_axi_rvalid && s_axi_rdata[15:8] == (UNIT_BUILT ? 8'h08 : 8'h00) && s_axi_rdata[0] == 1'b0)
        else $error("region count wrong");
    a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        res_o.fault && irq_enable[RPC_EVT_PROHIBIT] && !res_o.overlap |=> irq_o)
        else $error("interrupt missing");
endmodule
`default_nettype wire

//--- verif/rpc_core_model.sv
// Core side model: issues fetch and data accesses
`timescale 1ns/1ps
`default_nettype none
module rpc_core_model
    import rpc_pkg::*;
(
    input  wire logic       clk_i,
    output var rpc_access_t acc_o
);
    // One access per call; a released address shows its inverse
    task automatic issue(input logic [31:0] a, input logic w, input logic f);
        @(posedge clk_i);
        acc_o <= '{1'b1, a, w, f, 1'b0, 1'b0};
        @(posedge clk_i);
        acc_o <= '{1'b0, ~a, 1'b0, 1'b0, 1'b0, 1'b0};
        #1;
    endtask

    // Idle at time zero
    initial acc_o = '0;
endmodule
`default_nettype wire

//--- verif/rpc_checker_test.sv
// Testbench: register map, region matching and interrupt
`timescale 1ns/1ps
`default_nettype none
module rpc_checker_test
    import rpc_pkg::*;
;
    logic        clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [31:0] awa = 0, wd = 0, ara = 0, rd, got;
    logic        awr, wrr, bv, arr, rv, irq;
    logic [1:0]  bres, rres, resp;
    rpc_access_t acc;
    rpc_result_t res;
    int          n_errors = 0, checks = 0;

    // Clock, design and core model
    always #5 clk = ~clk;
    rpc_checker DUT
    (
        .clk_sys_i(clk), .resetn_i(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bres),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr), .acc_i(acc),
        .res_o(res), .irq_o(irq)
    );
    rpc_core_model core (.clk_i(clk), .acc_o(acc));

    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One bus write (w=1) or read (w=0), held until each channel is taken
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tr, dn;
        @(posedge clk);
        awa <= a;
        ara <= a;
        wd <= d;
        awv <= w;
        wv <= w;
        br <= w;
        arv <= !w;
        rr <= !w;
        dn = 0;
        while (!dn)
        begin
            @(negedge clk);
            ta = awv & awr;
            tw = wv & wrr;
            tr = arv & arr;
            dn = (bv & br) | (rv & rr);
            resp = w ? bres : rres;
            got = rd;
            @(posedge clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
            if (tr) arv <= 0;
        end
        br <= 0;
        rr <= 0;
        chk(32'(resp), 32'(er));
        if (!w) chk(got, d);
    endtask

    // One core access, then valid, fault and overlap
    task automatic ac(input logic [31:0] a, input logic f, input logic [1:0] e);
        core.issue(a, 1'b0, f);
        chk(32'({res.valid, res.fault, res.overlap}), 32'({1'b1, e}));
    endtask

    // Reset values, reserved bits, unmapped place, region storage
    task automatic t_regs;
        xfer(0, RPC_ADDR_UNIT_INFO, 32'h0000_0800, 2'h0);
        xfer(0, RPC_ADDR_CONTROL, 32'h0, 2'h0);
        xfer(1, RPC_ADDR_CONTROL, 32'hFFFF_FFF8, 2'h0);
        xfer(0, RPC_ADDR_CONTROL, 32'h0, 2'h0);
        xfer(0, 32'hE000_EDB0, 32'h0, 2'h2);
        xfer(1, RPC_ADDR_SELECT, 32'h1, 2'h0);
        xfer(1, RPC_ADDR_BASE, 32'h2000_0802, 2'h0);
        xfer(1, RPC_ADDR_LIMIT, 32'h2000_1FE3, 2'h0);
        xfer(1, RPC_ADDR_SELECT, 32'h0, 2'h0);
        xfer(1, RPC_ADDR_BASE, 32'h2000_0012, 2'h0);
        xfer(1, RPC_ADDR_LIMIT, 32'h2000_0FE1, 2'h0);
        xfer(1, RPC_ADDR_ATTR_LOW, 32'h0000_FF04, 2'h0);
        xfer(1, RPC_ADDR_ATTR_HIGH, 32'h1234_5678, 2'h0);
        xfer(0, RPC_ADDR_ATTR_LOW, 32'h0000_FF04, 2'h0);
        xfer(0, RPC_ADDR_ATTR_HIGH, 32'h1234_5678, 2'h0);
        xfer(0, RPC_ADDR_LIMIT, 32'h2000_0FE1, 2'h0);
        xfer(0, RPC_ADDR_BASE, 32'h2000_0012, 2'h0);
    endtask

    // Region hits, faults and exported attributes
    task automatic t_match;
        ac(32'h3000_0000, 1'b0, 2'b00);
        xfer(1, RPC_ADDR_CONTROL, 32'h1, 2'h0);
        ac(32'h3000_0000, 1'b0, 2'b10);
        ac(32'h2000_0100, 1'b0, 2'b00);
        chk(32'({res.attr, res.shareable, res.ordered}), 32'h013);
        ac(32'h2000_1000, 1'b0, 2'b00);
        chk(32'({res.attr, res.shareable, res.ordered}), 32'h3FC);
        chk(32'({res.hit, res.region}), 32'h11);
        ac(32'h2000_1000, 1'b1, 2'b00);
        chk(32'({res.attr, res.shareable, res.ordered}), 32'h3FC);
        ac(32'h2000_0900, 1'b0, 2'b11);
        ac(32'hE000_ED90, 1'b0, 2'b00);
        ac(32'h0000_0100, 1'b1, 2'b00);
        xfer(1, RPC_ADDR_SELECT, 32'h1, 2'h0);
        xfer(1, RPC_ADDR_BASE, 32'h2000_0803, 2'h0);
        ac(32'h2000_1000, 1'b1, 2'b10);
    endtask

    // Interrupt masked, raised and cleared
    task automatic t_irq;
        chk(32'(irq), 32'h0);
        xfer(1, RPC_ADDR_IRQ_ENABLE, 32'h3, 2'h0);
        #1 chk(32'(irq), 32'h1);
        xfer(1, RPC_ADDR_IRQ_CLEAR, 32'h3, 2'h0);
        #1 chk(32'(irq), 32'h0);
        xfer(0, RPC_ADDR_IRQ_STATUS, 32'h0, 2'h0);
        ac(32'h3000_0000, 1'b0, 2'b10);
        @(posedge clk);
        #1 chk(32'(irq), 32'h1);
        xfer(0, RPC_ADDR_FAULT_ADDR, 32'h3000_0000, 2'h0);
    endtask

    // Verdict and end of run
    task automatic test_done;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1;
        t_regs;
        t_match;
        t_irq;
        test_done;
    end

    // Watchdog
    initial
    begin
        #200us;
        n_errors++;
        test_done;
    end
endmodule
`default_nettype wire
